// File: rtl/tcdma_pkg.sv
// Shared constants, types and states of the two-channel transfer engine
`default_nettype none
package tcdma_pkg;
   localparam int NCH = 2;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 16;
   localparam int CNT_W = 16;
   localparam int BUF_DEPTH = 2;
   localparam logic [ADDR_W-1:0] STEP_BYTE = 16'h0001;
   localparam logic [ADDR_W-1:0] STEP_WORD = 16'h0002;
   localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

   // Channel setup, held by the surrounding control logic
   typedef struct packed {
      logic enable;
      logic srcFwd;
      logic dstFwd;
      logic repeatMode;
      logic wideUnit;
   } tcdma_cfg_t;

   // Values taken when a channel is loaded
   typedef struct packed {
      logic [ADDR_W-1:0] srcAddr;
      logic [ADDR_W-1:0] dstAddr;
      logic [CNT_W-1:0] count;
      logic [CNT_W-1:0] reload;
   } tcdma_load_t;

   typedef struct packed {
      logic req;
      logic we;
      logic wide;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } tcdma_mem_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_READ,
      ST_WAIT_BUF,
      ST_WRITE
   } tcdma_state_t;
endpackage
`default_nettype wire

// File: rtl/tcdma_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module tcdma_buf #(
   parameter int W = tcdma_pkg::DATA_W,
   parameter int DEPTH = tcdma_pkg::BUF_DEPTH
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic inValid,
   output logic inReady,
   input wire logic [W-1:0] inData,
   output logic outValid,
   input wire logic outReady,
   output logic [W-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0] mem_reg [DEPTH];
   logic [W-1:0] mem_next [DEPTH];
   logic [PW-1:0] wrPtr_reg, wrPtr_next, rdPtr_reg, rdPtr_next;
   logic [PW:0] fill_reg, fill_next;
   logic push, pop;

   assign inReady = (fill_reg != DEPTH[PW:0]);
   assign outValid = (fill_reg != '0);
   assign outData = mem_reg[rdPtr_reg];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      mem_next = mem_reg;
      wrPtr_next = wrPtr_reg;
      rdPtr_next = rdPtr_reg;
      fill_next = fill_reg;
      if (push) begin
         mem_next[wrPtr_reg] = inData;
         wrPtr_next = (wrPtr_reg == PW'(DEPTH - 1)) ? '0 : wrPtr_reg + 1'b1;
      end
      if (pop) begin
         rdPtr_next = (rdPtr_reg == PW'(DEPTH - 1)) ? '0 : rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
         fill_next = fill_reg + 1'b1;
      end else if (pop && !push) begin
         fill_next = fill_reg - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wrPtr_reg <= '0;
         rdPtr_reg <= '0;
         fill_reg <= '0;
      end else begin
         wrPtr_reg <= wrPtr_next;
         rdPtr_reg <= rdPtr_next;
         fill_reg <= fill_next;
      end
      // Data array needs no reset; fill count guards it
      mem_reg <= mem_next;
   end
endmodule
`default_nettype wire

// File: rtl/tcdma_engine.sv
// Two-channel transfer engine: request latching, arbitration, counters and bus sequencing
// Notes on behaviour
// - Each address steps forward per unit or stays fixed, per channel setup.
// - Single mode: channel stops after its counter underflows; channels independent.
// - Repeat mode: counter reloads from reload value on underflow and continues.
// - Interrupt request pulses when the counter underflows, in either mode.
// - One transfer unit is moved per accepted request.
// - Requests are accepted and transfers started only while enable is one.
// - When both channels are pending, channel zero is served first.
`timescale 1ns/1ps
`default_nettype none
module tcdma_engine (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tcdma_pkg::tcdma_cfg_t [tcdma_pkg::NCH-1:0] chCfg,
   input wire logic [tcdma_pkg::NCH-1:0] chLoad,
   input wire tcdma_pkg::tcdma_load_t [tcdma_pkg::NCH-1:0] chLoadVal,
   input wire logic [tcdma_pkg::NCH-1:0] chReq,
   output tcdma_pkg::tcdma_mem_t mem,
   input wire logic memAck,
   input wire logic [tcdma_pkg::DATA_W-1:0] memRData,
   output logic [tcdma_pkg::NCH-1:0] chIrq,
   output logic [tcdma_pkg::NCH-1:0] chHalted,
   output logic busy
);
   localparam int NCH = tcdma_pkg::NCH;
   localparam int AW = tcdma_pkg::ADDR_W;
   localparam int CW = tcdma_pkg::CNT_W;
   localparam int DW = tcdma_pkg::DATA_W;

   tcdma_pkg::tcdma_state_t state_reg, state_next;
   tcdma_pkg::tcdma_mem_t mem_reg, mem_next;
   logic [AW-1:0] src_reg [NCH];
   logic [AW-1:0] src_next [NCH];
   logic [AW-1:0] dst_reg [NCH];
   logic [AW-1:0] dst_next [NCH];
   logic [CW-1:0] cnt_reg [NCH];
   logic [CW-1:0] cnt_next [NCH];
   logic [CW-1:0] rld_reg [NCH];
   logic [CW-1:0] rld_next [NCH];
   logic [NCH-1:0] pend_reg, pend_next;
   logic [NCH-1:0] halt_reg, halt_next;
   logic [NCH-1:0] irq_reg, irq_next;
   logic [NCH-1:0] eligible;
   logic [NCH-1:0] grant;
   logic cur_reg, cur_next;
   logic busy_reg, busy_next;
   logic bufInValid, bufInReady, bufOutValid, bufOutReady;
   logic [DW-1:0] bufOutData;
   logic [AW-1:0] step;

   assign mem = mem_reg;
   assign chIrq = irq_reg;
   assign chHalted = halt_reg;
   assign busy = busy_reg;

   // Read data parks here so a slow write side loses no word
   tcdma_buf #(
      .W(DW),
      .DEPTH(tcdma_pkg::BUF_DEPTH)
   ) u_buf (
      .sys_clk(sys_clk),
      .rst(rst),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(memRData),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOutData)
   );

   assign bufInValid = (state_reg == tcdma_pkg::ST_READ) && memAck;
   assign bufOutReady = (state_reg == tcdma_pkg::ST_WRITE) && memAck;

   // Per-channel request latch; a new request beats the clear of the same cycle
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         // A disabled or halted channel drops its requests at once
         assign eligible[g] = chCfg[g].enable && !halt_reg[g];
         always_comb begin
            pend_next[g] = pend_reg[g] && !grant[g];
            if (chReq[g]) begin
               pend_next[g] = 1'b1;
            end
            if (!eligible[g]) begin
               pend_next[g] = 1'b0;
            end
         end
      end
   endgenerate

   // Fixed priority, channel zero wins
   // Reads wait for buffer room, so a stalled write never drops a word
   always_comb begin
      grant = '0;
      if (state_reg == tcdma_pkg::ST_IDLE && bufInReady) begin
         if (pend_reg[0] && eligible[0]) begin
            grant[0] = 1'b1;
         end else if (pend_reg[1] && eligible[1]) begin
            grant[1] = 1'b1;
         end
      end
   end

   // Step follows the unit size of the channel in flight
   assign step = chCfg[cur_reg].wideUnit ? tcdma_pkg::STEP_WORD : tcdma_pkg::STEP_BYTE;

   always_comb begin
      state_next = state_reg;
      mem_next = mem_reg;
      src_next = src_reg;
      dst_next = dst_reg;
      cnt_next = cnt_reg;
      rld_next = rld_reg;
      halt_next = halt_reg;
      // Interrupt is a one-cycle pulse unless set below
      irq_next = '0;
      cur_next = cur_reg;
      // Busy rises with the state but lags it by one cycle on return to idle
      busy_next = (state_reg != tcdma_pkg::ST_IDLE);
      unique case (state_reg)
         tcdma_pkg::ST_IDLE: begin
            if (|grant) begin
               cur_next = grant[1] && !grant[0];
               mem_next.req = 1'b1;
               mem_next.we = 1'b0;
               mem_next.wide = chCfg[cur_next].wideUnit;
               mem_next.addr = src_reg[cur_next];
               state_next = tcdma_pkg::ST_READ;
               busy_next = 1'b1;
            end
         end
         tcdma_pkg::ST_READ: begin
            // Request and address stand until the acknowledge edge
            if (memAck) begin
               mem_next.req = 1'b0;
               state_next = tcdma_pkg::ST_WAIT_BUF;
            end
         end
         tcdma_pkg::ST_WAIT_BUF: begin
            if (bufOutValid) begin
               mem_next.req = 1'b1;
               mem_next.we = 1'b1;
               mem_next.addr = dst_reg[cur_reg];
               mem_next.wdata = bufOutData;
               state_next = tcdma_pkg::ST_WRITE;
            end
         end
         tcdma_pkg::ST_WRITE: begin
            if (memAck) begin
               mem_next.req = 1'b0;
               mem_next.we = 1'b0;
               state_next = tcdma_pkg::ST_IDLE;
               if (chCfg[cur_reg].srcFwd) begin
                  src_next[cur_reg] = src_reg[cur_reg] + step;
               end
               if (chCfg[cur_reg].dstFwd) begin
                  dst_next[cur_reg] = dst_reg[cur_reg] + step;
               end
               // Single mode wraps to all ones; the halt flag keeps it unused
               if (cnt_reg[cur_reg] == tcdma_pkg::CNT_RST) begin
                  irq_next[cur_reg] = 1'b1;
                  if (chCfg[cur_reg].repeatMode) begin
                     cnt_next[cur_reg] = rld_reg[cur_reg];
                  end else begin
                     cnt_next[cur_reg] = cnt_reg[cur_reg] - tcdma_pkg::CNT_ONE;
                     halt_next[cur_reg] = 1'b1;
                  end
               end else begin
                  cnt_next[cur_reg] = cnt_reg[cur_reg] - tcdma_pkg::CNT_ONE;
               end
            end
         end
      endcase
      // Loading a channel rearms it; ignored for the channel in flight
      for (int i = 0; i < NCH; i++) begin
         if (chLoad[i] && !(busy_next && cur_next == i[0])) begin
            src_next[i] = chLoadVal[i].srcAddr;
            dst_next[i] = chLoadVal[i].dstAddr;
            cnt_next[i] = chLoadVal[i].count;
            rld_next[i] = chLoadVal[i].reload;
            halt_next[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_reg <= tcdma_pkg::ST_IDLE;
         mem_reg <= '{req: 1'b0, we: 1'b0, wide: 1'b0,
                      addr: tcdma_pkg::ADDR_RST, wdata: tcdma_pkg::DATA_RST};
         for (int i = 0; i < NCH; i++) begin
            src_reg[i] <= tcdma_pkg::ADDR_RST;
            dst_reg[i] <= tcdma_pkg::ADDR_RST;
            cnt_reg[i] <= tcdma_pkg::CNT_RST;
            rld_reg[i] <= tcdma_pkg::CNT_RST;
         end
         pend_reg <= '0;
         halt_reg <= '0;
         irq_reg <= '0;
         cur_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         // Outputs come straight from these registers
         state_reg <= state_next;
         mem_reg <= mem_next;
         src_reg <= src_next;
         dst_reg <= dst_next;
         cnt_reg <= cnt_next;
         rld_reg <= rld_next;
         pend_reg <= pend_next;
         halt_reg <= halt_next;
         irq_reg <= irq_next;
         cur_reg <= cur_next;
         busy_reg <= busy_next;
      end
   end
endmodule
`default_nettype wire

// File: testbench/tcdma_mem_model.sv
// Memory bus partner with chosen ack latency
`timescale 1ns/1ps
`default_nettype none
module tcdma_mem_model (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tcdma_pkg::tcdma_mem_t mem,
   input wire logic [1:0] lat,
   output logic memAck,
   output logic [15:0] memRData
);
   logic [2:0] wait_reg;
   // Data toggles outside the ack cycle, so a sample one cycle late never matches
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wait_reg <= 3'h0;
         memAck <= 1'b0;
         memRData <= 16'h0000;
      end else if (mem.req && !memAck && wait_reg >= {1'b0, lat}) begin
         wait_reg <= 3'h0;
         memAck <= 1'b1;
         memRData <= mem.we ? ~memRData : mem.addr ^ 16'h5a3c;
      end else begin
         wait_reg <= (mem.req && !memAck) ? wait_reg + 3'h1 : 3'h0;
         memAck <= 1'b0;
         memRData <= ~memRData;
      end
   end
endmodule
`default_nettype wire

// File: testbench/tcdma_engine_sva.sv
// Port checker for the transfer engine
`timescale 1ns/1ps
`default_nettype none
module tcdma_engine_sva (
   input wire logic sys_clk,
   input wire logic rst,
   input wire tcdma_pkg::tcdma_cfg_t [tcdma_pkg::NCH-1:0] chCfg,
   input wire logic [tcdma_pkg::NCH-1:0] chLoad,
   input wire tcdma_pkg::tcdma_load_t [tcdma_pkg::NCH-1:0] chLoadVal,
   input wire logic [tcdma_pkg::NCH-1:0] chReq,
   input wire tcdma_pkg::tcdma_mem_t mem,
   input wire logic memAck,
   input wire logic [tcdma_pkg::DATA_W-1:0] memRData,
   input wire logic [tcdma_pkg::NCH-1:0] chIrq,
   input wire logic [tcdma_pkg::NCH-1:0] chHalted,
   input wire logic busy
);
   logic [15:0] lastRd_reg;
   always_ff @(posedge sys_clk) begin
      if (rst) lastRd_reg <= 16'h0000;
      else if (memAck && !mem.we) lastRd_reg <= memRData;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_req_hold: assert property (mem.req && !memAck |=> mem.req && $stable(mem.addr))
      else $error("request changed before ack");
   a_write_data: assert property (mem.req && mem.we |-> mem.wdata == lastRd_reg)
      else $error("write data differs from read");
   a_write_follows: assert property ($fell(mem.req) && !$past(mem.we) |-> ##[1:8] mem.req && mem.we)
      else $error("no write after read");
   a_irq_cause: assert property (chIrq != 2'b00 |-> $past(memAck && mem.we))
      else $error("irq without finished unit");
   a_halt_irq: assert property ((chHalted & ~$past(chHalted) & ~chIrq) == 2'b00)
      else $error("halt without underflow");
   a_halt_single: assert property (chIrq[0] && !chCfg[0].repeatMode |-> chHalted[0])
      else $error("single mode not halted");
   a_repeat_runs: assert property (chIrq[1] && chCfg[1].repeatMode |-> !chHalted[1])
      else $error("repeat mode halted");
   // Three cycles with both channels halted or disabled let any pending request be flushed first
   a_quiet_off: assert property ((chHalted | ~{chCfg[1].enable, chCfg[0].enable}) == 2'b11 [*3]
      |-> !$rose(mem.req && !mem.we))
      else $error("read started while off");
   cover property (chIrq[0] && chCfg[0].repeatMode);
   cover property (chHalted[1] && chLoad[1]);
   cover property (mem.req && mem.we && mem.wide);
endmodule
bind tcdma_engine tcdma_engine_sva chk_i (.sys_clk(sys_clk), .rst(rst), .chCfg(chCfg),
   .chLoad(chLoad), .chLoadVal(chLoadVal), .chReq(chReq), .mem(mem), .memAck(memAck),
   .memRData(memRData), .chIrq(chIrq), .chHalted(chHalted), .busy(busy));
`default_nettype wire

// File: testbench/tcdma_engine_tb.sv
// Self-checking bench for the transfer engine
`timescale 1ns/1ps
`default_nettype none
module tcdma_engine_tb;
   logic sys_clk, rst, memAck, busy;
   logic [1:0] chLoad, chReq, chIrq, chHalted, lat;
   logic [15:0] memRData, ad, wd;
   logic wdw;
   logic [15:0] s[2], d[2];
   tcdma_pkg::tcdma_cfg_t [1:0] chCfg;
   tcdma_pkg::tcdma_load_t [1:0] chLoadVal;
   tcdma_pkg::tcdma_mem_t mem;
   int err_total, n_checks, n;
   tcdma_engine uut (.sys_clk(sys_clk), .rst(rst), .chCfg(chCfg), .chLoad(chLoad),
      .chLoadVal(chLoadVal), .chReq(chReq), .mem(mem), .memAck(memAck),
      .memRData(memRData), .chIrq(chIrq), .chHalted(chHalted), .busy(busy));
   tcdma_mem_model far (.sys_clk(sys_clk), .rst(rst), .mem(mem), .lat(lat),
      .memAck(memAck), .memRData(memRData));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Partner returns the read address scrambled by a fixed pattern
   function automatic logic [15:0] rdExp(input logic [15:0] a);
      return a ^ 16'h5a3c;
   endfunction
   task automatic waitAck(input logic w);
      int k;
      k = 0;
      while (!(memAck && mem.we === w) && k < 60) begin
         @(posedge sys_clk);
         #1 k++;
      end
      if (!(memAck && mem.we === w)) begin
         chk("ack", 16'h1, 16'h0);
         wrap_up();
      end else begin
         ad = mem.addr;
         wd = mem.wdata;
         wdw = mem.wide;
         @(posedge sys_clk);
         #1;
      end
   endtask
   task automatic unit(input int c, input logic irq);
      logic [15:0] st;
      st = chCfg[c].wideUnit ? 16'h0002 : 16'h0001;
      chReq[c] = 1'b1;
      @(posedge sys_clk);
      #1 chReq[c] = 1'b0;
      waitAck(1'b0);
      chk("src", s[c], ad);
      chk("busy", 16'h1, {15'h0, busy});
      waitAck(1'b1);
      chk("dst", d[c], ad);
      chk("data", rdExp(s[c]), wd);
      chk("wide", {15'h0, chCfg[c].wideUnit}, {15'h0, wdw});
      chk("irq", {15'h0, irq}, {15'h0, chIrq[c]});
      if (chCfg[c].srcFwd) s[c] += st;
      if (chCfg[c].dstFwd) d[c] += st;
   endtask
   task automatic setup(input int c, input logic rep, input logic [15:0] cn);
      logic sf;
      sf = 1'($urandom);
      chCfg[c] = {1'b1, sf, ~sf & 1'($urandom), rep, 1'($urandom)};
      s[c] = 16'($urandom);
      d[c] = 16'($urandom);
      chLoadVal[c] = {s[c], d[c], cn, 16'h0001};
      chLoad[c] = 1'b1;
      lat = 2'($urandom);
      @(posedge sys_clk);
      #1 chLoad[c] = 1'b0;
      chk("rearm", 16'h0, {15'h0, chHalted[c]});
   endtask
   task automatic quiet(input int c);
      logic seen;
      seen = 1'b0;
      chReq[c] = 1'b1;
      repeat (8) begin
         @(posedge sys_clk);
         #1 chReq[c] = 1'b0;
         seen |= mem.req;
      end
      chk("quiet", 16'h0, {15'h0, seen});
      chk("idle", 16'h0, {15'h0, busy});
   endtask
   initial begin
      rst = 1'b1;
      chCfg = '0;
      chLoadVal = '0;
      chLoad = 2'h0;
      chReq = 2'h0;
      lat = 2'h0;
      err_total = 0;
      n_checks = 0;
      void'($urandom(64782));
      repeat (3) @(posedge sys_clk);
      #1 rst = 1'b0;
      for (int i = 0; i < 8; i++) begin
         n = (i == 4) ? 0 : $urandom % 3;
         setup(i % 2, i[1], 16'(n));
         for (int j = 0; j <= n; j++) begin
            unit(i % 2, j == n);
         end
         if (i[1]) begin
            unit(i % 2, 1'b0);
            unit(i % 2, 1'b1);
            chk("run", 16'h0, {15'h0, chHalted[i % 2]});
         end else begin
            chk("halt", 16'h1, {15'h0, chHalted[i % 2]});
            quiet(i % 2);
         end
         $display("test %0d done", i);
      end
      setup(0, 1'b0, 16'h0000);
      chCfg[0].enable = 1'b0;
      quiet(0);
      setup(0, 1'b1, 16'h0005);
      setup(1, 1'b1, 16'h0005);
      chReq = 2'h3;
      @(posedge sys_clk);
      #1 chReq = 2'h0;
      waitAck(1'b0);
      chk("first", s[0], ad);
      waitAck(1'b1);
      waitAck(1'b0);
      chk("second", s[1], ad);
      waitAck(1'b1);
      $display("test 8 done");
      wrap_up();
   end
endmodule
`default_nettype wire
